// ---- sao_pkg.sv ----
// Shared constants for the serial audio output port
package sao_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] SAO_CTRL_ADDR = 12'h81E; // Serial output control word
  localparam logic [15:0] SAO_CTRL_RESET = 16'h0000; // Slave mode, 24-bit, stereo
  localparam logic [15:0] SAO_CTRL_WMASK = 16'h3FFF; // Top two bits read as zero

  // ****************************************************************
  // Field positions inside the control word
  // ****************************************************************
  localparam int SAO_POL_BIT = 13; // frame_clock_polarity
  localparam int SAO_EDGE_BIT = 12; // bit_clock_edge_select
  localparam int SAO_MS_BIT = 11; // Master when set
  localparam int SAO_BDIV_LSB = 9; // bit_clock_divide[1:0]
  localparam int SAO_FDIV_LSB = 7; // frame_clock_divide[1:0]
  localparam int SAO_SHAPE_BIT = 6; // frame_sync_shape
  localparam int SAO_TDM_BIT = 5; // Eight-channel stream on lane 0
  localparam int SAO_MSB_LSB = 2; // MSB position field [2:0]
  localparam int SAO_WL_LSB = 0; // out_word_length[1:0]

  // ****************************************************************
  // Stream geometry
  // ****************************************************************
  localparam int SAO_SAMPLE_W = 24; // Widest sample word
  localparam int SAO_CHANNELS = 8; // Channels held for output
  localparam int SAO_LANES = 4; // Stereo serial lanes
  localparam int SAO_SLOT_BITS = 32; // Bit clocks per channel slot
  localparam logic [8:0] SAO_POS_MAX = 9'h1FF; // Frame bit counter saturation
  localparam logic [8:0] SAO_STEREO_HALF = 9'h020; // Bit clocks per stereo half
  localparam logic [8:0] SAO_PULSE_FRAME = 9'h040; // Stereo frame in pulse mode
  localparam logic [8:0] SAO_TDM_FRAME = 9'h100; // Eight slots of 32

  // ****************************************************************
  // Word lengths and MSB delays
  // ****************************************************************
  localparam logic [4:0] SAO_WL_24 = 5'h18;
  localparam logic [4:0] SAO_WL_20 = 5'h14;
  localparam logic [4:0] SAO_WL_16 = 5'h10;
  localparam logic [4:0] SAO_DLY_0 = 5'h00;
  localparam logic [4:0] SAO_DLY_1 = 5'h01;
  localparam logic [4:0] SAO_DLY_8 = 5'h08;
  localparam logic [4:0] SAO_DLY_12 = 5'h0C;
  localparam logic [4:0] SAO_DLY_16 = 5'h10;

endpackage

// ---- sao_sample_mem.sv ----
// Small sample store with several registered read ports
`timescale 1ns/1ns

module sao_sample_mem #(
  parameter int DW = 24,
  parameter int DEPTH = 8,
  parameter int RP = 4,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [RP*AW-1:0] raddr_i,
  output logic [RP*DW-1:0] rdata_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem; // Sample words
    logic [RP-1:0][DW-1:0] rd; // Registered read data
  } sao_mem_state_t;

  sao_mem_state_t q, d;

  // Every port reads the old contents; a same-cycle write lands at the same edge
  always_comb begin
    d = q;
    if (we_i) begin
      d.mem[waddr_i] = wdata_i;
    end
    for (int i = 0; i < RP; i++) begin
      d.rd[i] = q.mem[raddr_i[i*AW +: AW]];
    end
  end

  // Silence after reset so lanes start quiet
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rd;

endmodule

// ---- sao_port.sv ----
// Serial audio output port: control word, clock master/slave, lane shifters
`timescale 1ns/1ns
// How it works
// - polarity bit chooses which frame level is left; pulse shape ignores it
// - edge bit picks falling or rising data change
// - reset leaves clocks as inputs until master set
// - master bit clock is internal clock over 16/8/4/2
// - master frame clock is internal over 1024/512/256
// - shape bit gives 50% word clock or pulse
// - TDM bit sends eight channels on lane zero
// - MSB field sets lag of first data bit
// - every sample goes out MSB first
// - word length 24/20/16, trailing slots driven zero

module sao_port (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [11:0] ctrl_addr_i,
  input wire logic [15:0] ctrl_wdata_i,
  input wire logic ctrl_we_i,
  output logic [15:0] ctrl_rdata_o,
  input wire logic sample_we_i,
  input wire logic [2:0] sample_ch_i,
  input wire logic [23:0] sample_data_i,
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe_o,
  input wire logic lrclk_i,
  output logic lrclk_o,
  output logic lrclk_oe_o,
  output logic [3:0] serial_out_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Decode the word length field; the reserved code falls back to 24
  function automatic logic [4:0] wl_of(input logic [1:0] code);
    case (code)
      2'h1: wl_of = sao_pkg::SAO_WL_20;
      2'h2: wl_of = sao_pkg::SAO_WL_16;
      default: wl_of = sao_pkg::SAO_WL_24;
    endcase
  endfunction

  // Decode the MSB position field; reserved codes behave as a lag of one
  function automatic logic [4:0] dly_of(input logic [2:0] code);
    case (code)
      3'h1: dly_of = sao_pkg::SAO_DLY_0;
      3'h2: dly_of = sao_pkg::SAO_DLY_8;
      3'h3: dly_of = sao_pkg::SAO_DLY_12;
      3'h4: dly_of = sao_pkg::SAO_DLY_16;
      default: dly_of = sao_pkg::SAO_DLY_1;
    endcase
  endfunction

  // Pick one bit of a sample, MSB first, zero past the word length
  function automatic logic bit_of(input logic [23:0] w, input logic [4:0] idx,
                                  input logic [4:0] wl);
    if (idx < wl) begin
      bit_of = w[5'h17 - idx];
    end else begin
      bit_of = 1'b0;
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0] ctrl; // serial_output_control
    logic [15:0] rdata; // Read data
    logic [9:0] mcnt; // Master divider from the 1024x clock
    logic bclk; // Master bit clock
    logic lrclk; // Master frame clock
    logic bs1; // Bit clock synchroniser, first stage
    logic bs2; // Bit clock synchroniser, second stage
    logic ls1; // Frame clock synchroniser, first stage
    logic ls2; // Frame clock synchroniser, second stage
    logic b_prev; // Bit clock seen last cycle
    logic edge_hit; // Data change edge seen last cycle
    logic lr_last; // Frame level at previous change edge
    logic [8:0] cnt; // Bit clocks since frame or half start
    logic [3:0] sdo; // Lane outputs
  } sao_state_t;

  sao_state_t q, d;

  logic master;
  logic pol;
  logic pulse;
  logic tdm;
  logic [4:0] wl;
  logic [4:0] dly;
  logic [3:0] bsel;
  logic [3:0] fsel;
  logic [9:0] mnext;
  logic [9:0] fmask;
  logic [9:0] bper;
  logic b_cur;
  logic lr;
  logic start;
  logic [8:0] pos;
  logic [8:0] pe;
  logic right;
  logic valid;
  logic [11:0] raddr;
  logic [95:0] rdata;

  // ****************************************************************
  // Sample store
  // ****************************************************************
  // Read addresses follow the bit about to be sent, so data is ready one cycle later
  sao_sample_mem #(
    .DW(sao_pkg::SAO_SAMPLE_W),
    .DEPTH(sao_pkg::SAO_CHANNELS),
    .RP(sao_pkg::SAO_LANES),
    .AW(3)
  ) u_mem (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .we_i(sample_we_i),
    .waddr_i(sample_ch_i),
    .wdata_i(sample_data_i),
    .raddr_i(raddr),
    .rdata_o(rdata)
  );

  // ****************************************************************
  // Field decode and frame position
  // ****************************************************************
  // Everything here is combinational from the registered state
  always_comb begin
    master = q.ctrl[sao_pkg::SAO_MS_BIT];
    pol = q.ctrl[sao_pkg::SAO_POL_BIT];
    pulse = q.ctrl[sao_pkg::SAO_SHAPE_BIT];
    tdm = q.ctrl[sao_pkg::SAO_TDM_BIT];
    wl = wl_of(q.ctrl[sao_pkg::SAO_WL_LSB +: 2]);
    dly = dly_of(q.ctrl[sao_pkg::SAO_MSB_LSB +: 3]);
    // Divider bit: /16 uses bit 3 down to /2 using bit 0
    bsel = 4'h3 - {2'h0, q.ctrl[sao_pkg::SAO_BDIV_LSB +: 2]};
    // Frame bit: /1024 bit 9, /512 bit 8, /256 bit 7; reserved acts as /256
    if (q.ctrl[sao_pkg::SAO_FDIV_LSB +: 2] == 2'h3) begin
      fsel = 4'h7;
    end else begin
      fsel = 4'h9 - {2'h0, q.ctrl[sao_pkg::SAO_FDIV_LSB +: 2]};
    end
    mnext = q.mcnt + 10'h001;
    fmask = 10'((11'h002 << fsel) - 11'h001);
    bper = 10'(11'h002 << bsel);
    // Slave clocks are read only after both synchroniser stages
    b_cur = master ? q.bclk : q.bs2;
    lr = master ? q.lrclk : q.ls2;
    // Frame or half start seen at this change edge
    if (pulse) begin
      start = lr && !q.lr_last;
    end else if (tdm) begin
      start = (lr != q.lr_last) && ((lr ^ pol) == 1'b0);
    end else begin
      start = lr != q.lr_last;
    end
    pos = start ? 9'h000 : q.cnt;
    pe = pos - {4'h0, dly};
    // Left sits on the low level with polarity 0, swapped with 1
    right = pulse ? pe[5] : (lr ^ pol);
    if (pos < {4'h0, dly}) begin
      valid = 1'b0;
    end else if (tdm) begin
      valid = pe < sao_pkg::SAO_TDM_FRAME;
    end else if (pulse) begin
      valid = pe < sao_pkg::SAO_PULSE_FRAME;
    end else begin
      valid = pe < sao_pkg::SAO_STEREO_HALF;
    end
    // Lane k carries channels 2k and 2k+1; TDM walks slots on lane 0
    for (int i = 0; i < sao_pkg::SAO_LANES; i++) begin
      if (tdm) begin
        raddr[i*3 +: 3] = (i == 0) ? pe[7:5] : 3'h0;
      end else begin
        raddr[i*3 +: 3] = {2'(i), right};
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    // Software writes the control word; top bits stay zero
    if (ctrl_we_i && (ctrl_addr_i == sao_pkg::SAO_CTRL_ADDR)) begin
      d.ctrl = ctrl_wdata_i & sao_pkg::SAO_CTRL_WMASK;
    end
    // Unmapped addresses read as zero
    if (ctrl_addr_i == sao_pkg::SAO_CTRL_ADDR) begin
      d.rdata = q.ctrl;
    end else begin
      d.rdata = 16'h0000;
    end
    // Pin synchronisers; first stage feeds only the second
    d.bs1 = bclk_i;
    d.bs2 = q.bs1;
    d.ls1 = lrclk_i;
    d.ls2 = q.ls1;
    // Master divider runs only while driving the pins
    if (master) begin
      d.mcnt = mnext;
      d.bclk = ~mnext[bsel];
      if (pulse) begin
        // One bit clock period high at the start of each frame
        d.lrclk = (mnext & fmask) < bper;
      end else begin
        // 50% word clock, first half on the left level
        d.lrclk = mnext[fsel] ^ pol;
      end
    end else begin
      d.mcnt = 10'h000;
      d.bclk = 1'b0;
      d.lrclk = 1'b0;
    end
    // Change edge: falling with edge bit 0, rising with 1
    d.b_prev = b_cur;
    if (q.ctrl[sao_pkg::SAO_EDGE_BIT]) begin
      d.edge_hit = b_cur && !q.b_prev;
    end else begin
      d.edge_hit = !b_cur && q.b_prev;
    end
    // Act one cycle after the edge so read data has settled
    if (q.edge_hit) begin
      d.lr_last = lr;
      d.cnt = (pos == sao_pkg::SAO_POS_MAX) ? pos : pos + 9'h001;
      for (int i = 0; i < sao_pkg::SAO_LANES; i++) begin
        if (tdm && (i != 0)) begin
          d.sdo[i] = 1'b0;
        end else begin
          d.sdo[i] = valid && bit_of(rdata[i*24 +: 24], pe[4:0], wl);
        end
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset gives slave mode with both clock pins released
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.ctrl <= sao_pkg::SAO_CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ctrl_rdata_o = q.rdata;
  assign bclk_o = q.bclk;
  assign lrclk_o = q.lrclk;
  assign bclk_oe_o = q.ctrl[sao_pkg::SAO_MS_BIT];
  assign lrclk_oe_o = q.ctrl[sao_pkg::SAO_MS_BIT];
  assign serial_out_o = q.sdo;

endmodule

// ---- sao_port_asserts.sv ----
// Port-level checker for the serial audio output port
`timescale 1ns/1ns
module sao_port_asserts (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [11:0] ctrl_addr_i,
  input wire logic [15:0] ctrl_wdata_i,
  input wire logic ctrl_we_i,
  input wire logic bclk_o,
  input wire logic bclk_oe_o,
  input wire logic lrclk_o,
  input wire logic lrclk_oe_o,
  input wire logic [3:0] serial_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [15:0] c_q; // Shadow of the control word
  logic [10:0] wr_n, bc_n, lr_n; // Cycles since write, bit and frame change
  logic b_p, l_p; // Clock outputs seen at the previous edge
  logic [10:0] h, half; // Expected half periods
  logic m, q; // Master, and master settled after a write
  assign m = c_q[11];
  // A write re-phases the dividers, so checks wait past a full frame
  assign q = m && wr_n > 11'h4B0;
  assign h = 11'h008 >> c_q[10:9];
  assign half = (c_q[8:7] == 2'h3) ? 11'h080 : 11'h200 >> c_q[8:7];
  // ****
  // Helper counters
  // ****
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      c_q <= 16'h0000;
      wr_n <= 11'h000;
      bc_n <= 11'h000;
      lr_n <= 11'h000;
      b_p <= 1'b0;
      l_p <= 1'b0;
    end else begin
      if (ctrl_we_i && ctrl_addr_i == sao_pkg::SAO_CTRL_ADDR) begin
        c_q <= ctrl_wdata_i & sao_pkg::SAO_CTRL_WMASK;
        wr_n <= 11'h000;
      end else if (wr_n != 11'h7FF) begin
        wr_n <= wr_n + 11'h001;
      end
      // Plain compare with last edge keeps the clock of this process unambiguous
      bc_n <= (bclk_o != b_p) ? 11'h001 : bc_n + 11'h001;
      lr_n <= (lrclk_o != l_p) ? 11'h001 : lr_n + 11'h001;
      b_p <= bclk_o;
      l_p <= lrclk_o;
    end
  end
  // ****
  // Properties
  // ****
  chk_oe_mode: assert property (bclk_oe_o == m && lrclk_oe_o == m)
    else $error("clock pin enables disagree with master bit");
  chk_slave_idle: assert property (!m && !$past(m) |-> !bclk_o && !lrclk_o)
    else $error("clock outputs active in slave mode");
  chk_bclk_div: assert property (q && $changed(bclk_o) |-> bc_n == h)
    else $error("bit clock half period wrong");
  chk_lr_div: assert property (q && !c_q[6] && $changed(lrclk_o) |-> lr_n == half)
    else $error("frame clock half period wrong");
  chk_pulse_high: assert property (q && c_q[6] && $fell(lrclk_o) |-> lr_n == (h << 1))
    else $error("frame pulse width wrong");
  chk_pulse_frame: assert property (q && c_q[6] && $rose(lrclk_o) |->
    lr_n == (half << 1) - (h << 1))
    else $error("frame pulse spacing wrong");
  chk_edge_sel: assert property (q && $changed(serial_out_o) |->
    $past(bclk_o, 2) != $past(bclk_o, 3) && $past(bclk_o, 2) == c_q[12])
    else $error("data changed away from the selected edge");
  chk_tdm_lanes: assert property (q && c_q[5] |-> serial_out_o[3:1] == 3'h0)
    else $error("upper lanes active in eight-channel mode");
  cover property (q && c_q[5] && serial_out_o[0]);
  cover property (q && c_q[6] && $rose(lrclk_o));
  cover property (!m && $changed(serial_out_o));
endmodule
bind sao_port sao_port_asserts u_chk (.clk_i, .resetn_i, .ctrl_addr_i, .ctrl_wdata_i,
  .ctrl_we_i, .bclk_o, .bclk_oe_o, .lrclk_o, .lrclk_oe_o, .serial_out_o);

// ---- sao_dac_model.sv ----
// Far-side converter model: slave clock source and single-lane capture
`timescale 1ns/1ns
module sao_dac_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic bclk_w_i,
  input wire logic lrclk_w_i,
  input wire logic sdata_i,
  output logic bclk_o,
  output logic lrclk_o,
  output logic [31:0] word_lo_o,
  output logic [31:0] word_hi_o
);
  logic [9:0] cnt; // Divider for the clocks we supply
  logic [31:0] sh; // Last 32 bits seen
  logic lr_q; // Frame level at previous sample
  // ****
  // Clocks: 16 clk bit period, 64 bits a frame, still when idle
  // ****
  always @(posedge clk_i) begin
    cnt <= run_i ? cnt + 10'h001 : 10'h000;
  end
  assign bclk_o = run_i & ~cnt[3];
  assign lrclk_o = run_i & cnt[9];
  // ****
  // Capture a tick after the rising edge, once frame level has settled
  // ****
  always @(posedge bclk_w_i) begin
    #1;
    sh = {sh[30:0], sdata_i};
    if (lrclk_w_i !== lr_q) begin
      if (lr_q) word_hi_o = sh;
      else word_lo_o = sh;
    end
    lr_q = lrclk_w_i;
  end
endmodule

// ---- serial_audio_output_port_tb_top.sv ----
// Self-checking bench for the serial audio output port
`timescale 1ns/1ns
module serial_audio_output_port_tb_top;
  localparam logic [23:0] SL = 24'h9ABCDF; // Left sample
  localparam logic [23:0] SR = 24'hC3E5A7; // Right sample
  localparam logic [23:0] SX = 24'h5A5A5A; // Other channels
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [11:0] ctrl_addr_i = 12'h000;
  logic [15:0] ctrl_wdata_i = 16'h0000;
  logic ctrl_we_i = 1'b0;
  logic sample_we_i = 1'b0;
  logic [2:0] sample_ch_i = 3'h0;
  logic [23:0] sample_data_i = 24'h000000;
  logic run = 1'b0; // Far side supplies clocks
  logic bclk_i, lrclk_i, bclk_m, lrclk_m, bclk_o, bclk_oe_o, lrclk_o, lrclk_oe_o;
  logic [15:0] ctrl_rdata_o;
  logic [3:0] serial_out_o;
  logic [31:0] w_lo, w_hi; // Words caught per frame half
  logic [31:0] w1_lo, w1_hi; // Lane 1 words per frame half
  int num_errors = 0;
  int compares = 0;
  // Pin level: the enabled party drives it
  assign bclk_i = bclk_oe_o ? bclk_o : bclk_m;
  assign lrclk_i = lrclk_oe_o ? lrclk_o : lrclk_m;
  sao_port dut (.clk_i, .resetn_i, .ctrl_addr_i, .ctrl_wdata_i, .ctrl_we_i, .ctrl_rdata_o,
    .sample_we_i, .sample_ch_i, .sample_data_i, .bclk_i, .bclk_o, .bclk_oe_o, .lrclk_i,
    .lrclk_o, .lrclk_oe_o, .serial_out_o);
  sao_dac_model u_far (.clk_i, .run_i(run), .bclk_w_i(bclk_i), .lrclk_w_i(lrclk_i),
    .sdata_i(serial_out_o[0]), .bclk_o(bclk_m), .lrclk_o(lrclk_m), .word_lo_o(w_lo),
    .word_hi_o(w_hi));
  // Second listener on lane 1; its clock outputs are not used
  sao_dac_model u_far1 (.clk_i, .run_i(run), .bclk_w_i(bclk_i), .lrclk_w_i(lrclk_i),
    .sdata_i(serial_out_o[1]), .bclk_o(), .lrclk_o(), .word_lo_o(w1_lo),
    .word_hi_o(w1_hi));
  initial forever #25 clk_i = ~clk_i;
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_i);
    ctrl_addr_i <= a;
    ctrl_wdata_i <= d;
    ctrl_we_i <= 1'b1;
    @(posedge clk_i);
    ctrl_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk_i);
    ctrl_addr_i <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("control read", {16'h0000, e}, {16'h0000, ctrl_rdata_o});
  endtask
  task automatic smp(input logic [2:0] c, input logic [23:0] d);
    @(posedge clk_i);
    sample_we_i <= 1'b1;
    sample_ch_i <= c;
    sample_data_i <= d;
    @(posedge clk_i);
    sample_we_i <= 1'b0;
  endtask
  // Configure, let three frames pass, judge both halves of the last
  task automatic frm(input logic [15:0] c, input int d, input int w,
                     input logic [23:0] a, input logic [23:0] b);
    logic [31:0] mk;
    logic [31:0] x;
    mk = ~(32'hFFFFFFFF >> w);
    // Lane 1 carries channels 2 and 3 in stereo, nothing in eight-channel mode
    x = c[5] ? 32'h0 : ({SX, 8'h00} & mk) >> d;
    wr(12'h81E, c);
    repeat (3200) @(posedge clk_i);
    chk("low half word", ({a, 8'h00} & mk) >> d, w_lo);
    chk("high half word", ({b, 8'h00} & mk) >> d, w_hi);
    chk("lane one low word", x, w1_lo);
    chk("lane one high word", x, w1_hi);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reg();
    rd(12'h81E, 16'h0000);
    chk("pin enables", 32'({bclk_oe_o, lrclk_oe_o}), 32'h0);
    wr(12'h81E, 16'hFFFF);
    rd(12'h81E, 16'h3FFF);
    rd(12'h81F, 16'h0000);
    wr(12'h81E, 16'h0000);
  endtask
  task automatic t_clk();
    logic [15:0] cfg [3];
    cfg = '{16'h1A80, 16'h0D40, 16'h1FC0};
    foreach (cfg[i]) begin
      wr(12'h81E, cfg[i]);
      rd(12'h81E, cfg[i]);
      repeat (2600) @(posedge clk_i);
    end
  endtask
  task automatic t_slave();
    @(posedge clk_i);
    run <= 1'b1;
    frm(16'h0000, 1, 24, SL, SR);
    chk("slave enables", 32'({bclk_oe_o, lrclk_oe_o}), 32'h0);
    @(posedge clk_i);
    run <= 1'b0;
  endtask
  // Reset in mid-run from master mode must release both clock pins again
  task automatic t_rst();
    wr(12'h81E, 16'h0800);
    repeat (40) @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    chk("reset enables", 32'({bclk_oe_o, lrclk_oe_o}), 32'h0);
    chk("reset outputs", 32'({bclk_o, lrclk_o, serial_out_o}), 32'h0);
    rd(12'h81E, 16'h0000);
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****
  // Main sequence; the frame cases run as I2S, swapped, late and TDM
  // ****
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reg();
    smp(3'h0, SL);
    smp(3'h1, SR);
    for (int i = 2; i < 8; i++) smp(3'(i), SX);
    frm(16'h0800, 1, 24, SL, SR);
    frm(16'h2805, 0, 20, SR, SL);
    frm(16'h080A, 8, 16, SL, SR);
    frm(16'h0A20, 1, 24, SR, SX);
    t_clk();
    t_slave();
    t_rst();
    results();
  end
  // Watchdog: the run needs about 24000 cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    results();
  end
endmodule
